//--- pkg/pcf_pkg.sv
// package for the port configuration and fault timer block
// assumes a 100 MHz clock and an 8-bit register port behind the management interface
package pcf_pkg;

  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam logic [7:0] MIDSPAN_SELECT_OFS = 8'h04;
  localparam logic [7:0] PORT_POWER_ENABLE_OFS = 8'h05;
  localparam logic [7:0] DETECT_CLASSIFY_ENABLE_OFS = 8'h06;
  localparam logic [7:0] DISCONNECT_MONITOR_ENABLE_OFS = 8'h07;
  localparam logic [7:0] FAULT_TIMER_DURATIONS_OFS = 8'h08;
  localparam logic [7:0] FOLDBACK_LIMIT_SELECT_OFS = 8'h0B;

  // ***************************************************************
  // field positions, masks and reset values
  // ***************************************************************
  localparam int NUM_PORTS = 4;
  localparam int NUM_TIMERS = 4;
  localparam int GLOBAL_EN_BIT = 4;
  localparam int CLASSIFY_LSB = 4;
  localparam int OVERLOAD_LSB = 6;
  localparam int INRUSH_LSB = 4;
  localparam int LIMIT_TRIG_LSB = 2;
  localparam int CUTOFF_LSB = 0;
  localparam logic [7:0] MIDSPAN_MASK = 8'h0F;
  localparam logic [7:0] POWER_EN_MASK = 8'h1F;
  localparam logic [7:0] DISCONNECT_MASK = 8'h0F;
  localparam logic [7:0] FOLDBACK_MASK = 8'h01;
  localparam logic [7:0] POWER_EN_RESET = 8'h1F;
  localparam logic [7:0] FAULT_TIMER_RESET = 8'hAE;
  localparam logic [7:0] FOLDBACK_RESET = 8'h01;

  // ***************************************************************
  // port modes
  // ***************************************************************
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MODE_AUTO = 2'h3;

  // ***************************************************************
  // timing: one tick is 1/8 of the 7.5 ms shortest duration
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 937500;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] UP_STEP = 12'h010;
  localparam logic [CNT_W-1:0] DOWN_STEP = 12'h001;
  localparam logic [CNT_W-1:0] LIMIT_BASE_15MS = 12'h100;
  localparam logic [CNT_W-1:0] LIMIT_BASE_7P5MS = 12'h080;

endpackage : pcf_pkg

//--- verilog/pcf_port_config.sv
// port configuration registers and per-port fault timers
// assumes a management-interface front end that presents byte reads and
// writes as one-cycle strobes, and analog comparators synchronous to clock
`timescale 1ns/10ps

module pcf_port_config import pcf_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
)
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // strap pins
  input wire logic midspanStrap,
  input wire logic autoStrap,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // port operating modes, two bits per port
  input wire logic [7:0] portOperatingSel,
  // comparator levels, bit port*4+timer: 0 overload,1 inrush,2 limit,3 cutoff
  input wire logic [15:0] overThreshold,
  // port controls
  output logic [3:0] portOutputPin,
  output logic [3:0] detectRun,
  output logic [3:0] classifyRun,
  output logic [3:0] unplugWatch,
  output logic [3:0] midspanMode,
  output logic [3:0] redetectBlocked,
  output logic foldbackLevelSel
);

  // ***************************************************************
  // registers and decode
  // ***************************************************************
  logic [3:0] midspan_r;
  logic [4:0] powerEn_r;
  logic [7:0] detCls_r;
  logic [7:0] detCls_nxt;
  logic [3:0] unplug_r;
  logic [7:0] timerSel_r;
  logic foldback_r;
  logic [7:0] regRdData_r;
  logic [3:0] fault_r;
  logic [3:0] power_r;
  logic [3:0] detRun_r;
  logic [3:0] clsRun_r;
  logic [3:0] blocked_r;
  logic [$clog2(TICK_LEN+1)-1:0] tickCnt_r;
  logic tick;
  logic [15:0] expired;
  logic [15:0] nonZero;
  logic [3:0] portEnabled;
  logic [3:0] manualPort;
  logic [3:0] runPort;
  logic [7:0] rdMux;
  logic [3:0] midspan_nxt;
  logic [4:0] powerEn_nxt;
  logic [3:0] unplug_nxt;
  logic [7:0] timerSel_nxt;
  logic foldback_nxt;
  logic [7:0] regRdData_nxt;
  logic [3:0] portExpired;
  logic [3:0] portNonZero;
  logic [3:0] fault_nxt;
  logic [3:0] power_nxt;
  logic [3:0] blocked_nxt;
  logic [3:0] detRun_nxt;
  logic [3:0] clsRun_nxt;
  logic [7:0] rdMid;
  logic [7:0] rdPen;
  logic [7:0] rdDis;
  logic [7:0] rdFbk;

  // address strobes
  wire wrMid = regWrite && (regAddr == MIDSPAN_SELECT_OFS);
  wire wrPen = regWrite && (regAddr == PORT_POWER_ENABLE_OFS);
  wire wrDet = regWrite && (regAddr == DETECT_CLASSIFY_ENABLE_OFS);
  wire wrDis = regWrite && (regAddr == DISCONNECT_MONITOR_ENABLE_OFS);
  wire wrTim = regWrite && (regAddr == FAULT_TIMER_DURATIONS_OFS);
  wire wrFbk = regWrite && (regAddr == FOLDBACK_LIMIT_SELECT_OFS);
  wire globalEn = powerEn_r[GLOBAL_EN_BIT];

  // read values with reserved bits forced to zero
  assign rdMid = {4'h0, midspan_r};
  assign rdPen = {3'h0, powerEn_r};
  assign rdDis = {4'h0, unplug_r};
  assign rdFbk = {7'h00, foldback_r};

  // read mux, unmapped offsets read zero
  assign rdMux =
    (regAddr == MIDSPAN_SELECT_OFS) ? rdMid :
    (regAddr == PORT_POWER_ENABLE_OFS) ? rdPen :
    (regAddr == DETECT_CLASSIFY_ENABLE_OFS) ? detCls_r :
    (regAddr == DISCONNECT_MONITOR_ENABLE_OFS) ? rdDis :
    (regAddr == FAULT_TIMER_DURATIONS_OFS) ? timerSel_r :
    (regAddr == FOLDBACK_LIMIT_SELECT_OFS) ? rdFbk : 8'h00;

  // ***************************************************************
  // configuration registers
  // ***************************************************************
  // next values; a write replaces only the defined bits
  assign midspan_nxt = wrMid ? (regWrData[3:0] & MIDSPAN_MASK[3:0]) : midspan_r;
  assign powerEn_nxt = wrPen ? (regWrData[4:0] & POWER_EN_MASK[4:0]) : powerEn_r;
  assign unplug_nxt = wrDis ? (regWrData[3:0] & DISCONNECT_MASK[3:0]) : unplug_r;
  assign timerSel_nxt = wrTim ? regWrData : timerSel_r;
  assign foldback_nxt = wrFbk ? (regWrData[0] & FOLDBACK_MASK[0]) : foldback_r;
  // reads never depend on the enables, so the host keeps full access
  // while every port is shut down
  assign regRdData_nxt = regRead ? rdMux : regRdData_r;

  // straps are caught in the synchronous reset branch, so they follow
  // whatever level the pins hold while srst is high
  always_ff @(posedge clock)
  begin
    if (srst)
      midspan_r <= {4{midspanStrap}};
    else
      midspan_r <= midspan_nxt;
  end

  // global and per-port enables, all on out of reset
  always_ff @(posedge clock)
  begin
    if (srst)
      powerEn_r <= POWER_EN_RESET[4:0];
    else
      powerEn_r <= powerEn_nxt;
  end

  // detect and classify requests follow the automatic-mode strap
  always_ff @(posedge clock)
  begin
    if (srst)
      detCls_r <= {8{autoStrap}};
    else
      detCls_r <= detCls_nxt;
  end

  // disconnect monitor enables, same strap as detect and classify
  always_ff @(posedge clock)
  begin
    if (srst)
      unplug_r <= {4{autoStrap}};
    else
      unplug_r <= unplug_nxt;
  end

  // fault timer duration codes
  always_ff @(posedge clock)
  begin
    if (srst)
      timerSel_r <= FAULT_TIMER_RESET;
    else
      timerSel_r <= timerSel_nxt;
  end

  // foldback threshold select, 40 mV out of reset
  always_ff @(posedge clock)
  begin
    if (srst)
      foldback_r <= FOLDBACK_RESET[0];
    else
      foldback_r <= foldback_nxt;
  end

  // read data register, holds until the next read strobe
  always_ff @(posedge clock)
  begin
    if (srst)
      regRdData_r <= 8'h00;
    else
      regRdData_r <= regRdData_nxt;
  end

  // ***************************************************************
  // per-port mode decode
  // ***************************************************************
  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++)
    begin : g_port
      wire [1:0] mode = portOperatingSel[2*gp+1:2*gp];
      assign portEnabled[gp] = globalEn && powerEn_r[gp];
      // per-port summaries of the four timers
      assign portExpired[gp] = |expired[gp*NUM_TIMERS +: NUM_TIMERS];
      assign portNonZero[gp] = |nonZero[gp*NUM_TIMERS +: NUM_TIMERS];
      assign manualPort[gp] = (mode == MODE_MANUAL);
      // semi-automatic codes run the processes like automatic
      assign runPort[gp] = (mode != MODE_SHUTDOWN) && portEnabled[gp];
    end
  endgenerate

  // manual one-shot: device clears run bits, a host write in the
  // same cycle wins so a fresh request is never lost
  always_comb
  begin
    detCls_nxt = detCls_r;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (manualPort[p] && runPort[p] && !blocked_r[p])
      begin
        detCls_nxt[p] = 1'b0;
        detCls_nxt[p+CLASSIFY_LSB] = 1'b0;
      end
    end
    if (wrDet)
      detCls_nxt = regWrData;
  end

  // ***************************************************************
  // fault timers
  // ***************************************************************
  // tick prescaler; counts hold sixteenths of a tick, so rising steps
  // 16 and falling steps 1 per tick
  assign tick = (tickCnt_r == '0);
  always_ff @(posedge clock)
  begin
    if (srst || tick)
      tickCnt_r <= ($clog2(TICK_LEN+1))'(TICK_LEN - 1);
    else
      tickCnt_r <= tickCnt_r - 1'b1;
  end

  genvar gt;
  generate
    for (gt = 0; gt < NUM_PORTS*NUM_TIMERS; gt++)
    begin : g_timer
      localparam int P = gt / NUM_TIMERS;
      localparam int T = gt % NUM_TIMERS;
      localparam int LSB = (T == 0) ? OVERLOAD_LSB : (T == 1) ? INRUSH_LSB :
        (T == 2) ? LIMIT_TRIG_LSB : CUTOFF_LSB;
      logic [CNT_W-1:0] cnt_r;
      logic [CNT_W-1:0] cnt_nxt;
      wire [1:0] sel = timerSel_r[LSB+1:LSB];
      // duration doubles with each code step
      wire [CNT_W-1:0] limit = (T == 2) ? (LIMIT_BASE_7P5MS << sel) :
        (LIMIT_BASE_15MS << sel);
      wire over = overThreshold[gt] && power_r[P];
      assign expired[gt] = (cnt_r >= limit);
      assign nonZero[gt] = (cnt_r != '0);
      always_comb
      begin
        cnt_nxt = cnt_r;
        if (tick && over)
          cnt_nxt = (cnt_r + UP_STEP > limit) ? limit : cnt_r + UP_STEP;
        else if (tick && nonZero[gt])
          cnt_nxt = cnt_r - DOWN_STEP;
      end
      always_ff @(posedge clock)
      begin
        if (srst || !portEnabled[P])
          cnt_r <= '0;
        else
          cnt_r <= cnt_nxt;
      end
    end
  endgenerate

  // ***************************************************************
  // port outputs
  // ***************************************************************
  // fault stays latched until every timer of the port has drained;
  // a fresh expiry wins over the drain and over a disable in one cycle
  always_comb
  begin
    fault_nxt = fault_r;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (portExpired[p])
        fault_nxt[p] = 1'b1;
      else if (!portNonZero[p] || !portEnabled[p])
        fault_nxt[p] = 1'b0;
    end
  end

  // power drops on the edge after expiry, not one later
  assign power_nxt = runPort & ~fault_r & ~portExpired;
  assign blocked_nxt = fault_r & portNonZero;
  // processes wait while the port is blocked
  assign detRun_nxt = runPort & detCls_r[0 +: NUM_PORTS] & ~blocked_r;
  assign clsRun_nxt = runPort & detCls_r[CLASSIFY_LSB +: NUM_PORTS] & ~blocked_r;

  // fault latch and redetection block
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      fault_r <= 4'h0;
      blocked_r <= 4'h0;
    end
    else
    begin
      fault_r <= fault_nxt;
      blocked_r <= blocked_nxt;
    end
  end

  // port drive and process requests
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      power_r <= 4'h0;
      detRun_r <= 4'h0;
      clsRun_r <= 4'h0;
    end
    else
    begin
      power_r <= power_nxt;
      detRun_r <= detRun_nxt;
      clsRun_r <= clsRun_nxt;
    end
  end

  assign regRdData = regRdData_r;
  assign portOutputPin = power_r;
  assign detectRun = detRun_r;
  assign classifyRun = clsRun_r;
  assign unplugWatch = unplug_r;
  assign midspanMode = midspan_r;
  assign redetectBlocked = blocked_r;
  assign foldbackLevelSel = foldback_r;

endmodule : pcf_port_config

//--- bench/pcf_monitor.sv
// checker for the port configuration block, bound to every instance
// assumes synchronous active-high reset and one-cycle register strobes
`timescale 1ns/10ps
module pcf_monitor import pcf_pkg::*;
(
  // clock, reset, straps
  input wire logic clock,
  input wire logic srst,
  input wire logic midspanStrap,
  input wire logic autoStrap,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // port side
  input wire logic [7:0] portOperatingSel,
  input wire logic [15:0] overThreshold,
  input wire logic [3:0] portOutputPin,
  input wire logic [3:0] detectRun,
  input wire logic [3:0] classifyRun,
  input wire logic [3:0] unplugWatch,
  input wire logic [3:0] midspanMode,
  input wire logic [3:0] redetectBlocked,
  input wire logic foldbackLevelSel
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // ****************************************
  // sequences
  // ****************************************
  sequence s_all_off_wr;
    regWrite && regAddr == PORT_POWER_ENABLE_OFS && !regWrData[GLOBAL_EN_BIT];
  endsequence
  // mode guard keeps an auto-mode level from looking like a pulse
  sequence s_manual_run;
    portOperatingSel[1:0] == MODE_MANUAL && $stable(portOperatingSel) && detectRun[0];
  endsequence
  // ****************************************
  // properties
  // ****************************************
  property p_all_off; s_all_off_wr ##1 !regWrite [*3] |-> portOutputPin == 4'h0; endproperty
  a_all_off: assert property (p_all_off) else $error("port on after global off");
  property p_manual_pulse; s_manual_run |=> !detectRun[0]; endproperty
  a_manual_pulse: assert property (p_manual_pulse) else $error("manual run too long");
  property p_reset_vals;
    $fell(srst) |-> regRdData == 8'h00 && portOutputPin == 4'h0 && foldbackLevelSel
      && midspanMode == {4{midspanStrap}} && unplugWatch == {4{autoStrap}};
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");
  property p_rd_mid; regRead && regAddr == MIDSPAN_SELECT_OFS |=>
    regRdData == {4'h0, $past(midspanMode)}; endproperty
  a_rd_mid: assert property (p_rd_mid) else $error("midspan read wrong");
  property p_rd_disc; regRead && regAddr == DISCONNECT_MONITOR_ENABLE_OFS |=>
    regRdData == {4'h0, $past(unplugWatch)}; endproperty
  a_rd_disc: assert property (p_rd_disc) else $error("disconnect read wrong");
  property p_rd_fold; regRead && regAddr == FOLDBACK_LIMIT_SELECT_OFS |=>
    regRdData == {7'h00, $past(foldbackLevelSel)}; endproperty
  a_rd_fold: assert property (p_rd_fold) else $error("foldback read wrong");
  property p_unmapped; regRead && !(regAddr inside {[8'h04:8'h08], 8'h0B}) |=>
    regRdData == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_blocked_off;
    (redetectBlocked & $past(redetectBlocked) & portOutputPin) == 4'h0;
  endproperty
  a_blocked_off: assert property (p_blocked_off) else $error("blocked port powered");
endmodule : pcf_monitor
bind pcf_port_config pcf_monitor mon_u (.clock, .srst, .midspanStrap, .autoStrap, .regAddr,
  .regWrData, .regWrite, .regRead, .regRdData, .portOperatingSel, .overThreshold,
  .portOutputPin, .detectRun, .classifyRun, .unplugWatch, .midspanMode, .redetectBlocked,
  .foldbackLevelSel);

//--- bench/pcf_load_model.sv
// load and comparator stand-in for the four ports
// assumes the bench names which comparator of which port sees excess load
`timescale 1ns/10ps
module pcf_load_model
(
  // bench command and port state
  input wire logic [15:0] heavyLoad,
  input wire logic [3:0] portOutputPin,
  // comparator levels
  output logic [15:0] overThreshold
);
  // an unpowered port draws nothing, so its comparators drop at once
  always_comb
  begin
    for (int p = 0; p < 4; p++)
      overThreshold[p*4 +: 4] = heavyLoad[p*4 +: 4] & {4{portOutputPin[p]}};
  end
endmodule : pcf_load_model

//--- bench/pcf_port_config_test.sv
// self-checking bench for the port configuration block
// assumes the load model beside it and a short tick for run time
`timescale 1ns/10ps
module pcf_port_config_test import pcf_pkg::*;
();
  localparam int TICK = 4;
  // design pins and bench state
  logic clock, srst, midspanStrap, autoStrap, regWrite, regRead, foldbackLevelSel;
  logic [7:0] regAddr, regWrData, regRdData, portOperatingSel, a;
  logic [15:0] overThreshold, heavyLoad;
  logic [3:0] portOutputPin, detectRun, classifyRun, unplugWatch, midspanMode, redetectBlocked;
  logic [1:0] sel;
  logic [7:0] addrs [7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0B, 8'h0C};
  int errors = 0;
  int checks = 0;
  int n, lim;
  pcf_port_config #(.TICK_LEN(TICK)) dut_u (.clock, .srst, .midspanStrap, .autoStrap,
    .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .portOperatingSel, .overThreshold,
    .portOutputPin, .detectRun, .classifyRun, .unplugWatch, .midspanMode, .redetectBlocked,
    .foldbackLevelSel);
  pcf_load_model load_u (.heavyLoad, .portOutputPin, .overThreshold);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] mask_of(input logic [7:0] ad);
    case (ad)
      MIDSPAN_SELECT_OFS: return MIDSPAN_MASK;
      PORT_POWER_ENABLE_OFS: return POWER_EN_MASK;
      DETECT_CLASSIFY_ENABLE_OFS, FAULT_TIMER_DURATIONS_OFS: return 8'hFF;
      DISCONNECT_MONITOR_ENABLE_OFS: return DISCONNECT_MASK;
      FOLDBACK_LIMIT_SELECT_OFS: return FOLDBACK_MASK;
      default: return 8'h00;
    endcase
  endfunction : mask_of
  // tick phase and output register make the count a little loose
  function automatic logic near(input int got, input int want);
    return got >= want - TICK - 4 && got <= want + TICK + 4;
  endfunction : near
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(negedge clock);
    regAddr = ad;
    regWrData = dt;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
    @(negedge clock);
    regAddr = ad;
    regRead = 1'b1;
    @(negedge clock);
    regRead = 1'b0;
    @(negedge clock);
    chk(regRdData, exp);
  endtask : rd_chk
  task automatic wait_lvl(input int blk, input int p, input logic lvl, input int lm);
    n = 0;
    while ((blk ? redetectBlocked[p] : portOutputPin[p]) !== lvl && n < lm)
    begin
      @(negedge clock);
      n++;
    end
    if (n >= lm)
    begin
      errors++;
      $display("unexpected at %0t: wait ran out", $time);
      tally_and_finish();
    end
  endtask : wait_lvl
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  // clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // main sequence
  initial
  begin
    {srst, regWrite, regRead, regAddr, regWrData, heavyLoad} = {1'b1, 34'h0};
    portOperatingSel = 8'hFF;
    void'($urandom(96435));
    midspanStrap = 1'($urandom);
    autoStrap = 1'($urandom);
    repeat (16) @(negedge clock);
    srst = 1'b0;
    rd_chk(MIDSPAN_SELECT_OFS, {4'h0, {4{midspanStrap}}});
    rd_chk(PORT_POWER_ENABLE_OFS, POWER_EN_RESET);
    rd_chk(DETECT_CLASSIFY_ENABLE_OFS, {8{autoStrap}});
    rd_chk(DISCONNECT_MONITOR_ENABLE_OFS, {4'h0, {4{autoStrap}}});
    rd_chk(FAULT_TIMER_DURATIONS_OFS, FAULT_TIMER_RESET);
    rd_chk(FOLDBACK_LIMIT_SELECT_OFS, FOLDBACK_RESET);
    chk({midspanMode, unplugWatch}, {{4{midspanStrap}}, {4{autoStrap}}});
    chk({7'h0, foldbackLevelSel}, FOLDBACK_RESET);
    for (int i = 0; i < 28; i++)
    begin
      a = addrs[i % 7];
      wr(a, 8'($urandom));
      rd_chk(a, regWrData & mask_of(a));
      if (a == MIDSPAN_SELECT_OFS)
        chk({4'h0, midspanMode}, regWrData & MIDSPAN_MASK);
      if (a == DISCONNECT_MONITOR_ENABLE_OFS)
        chk({4'h0, unplugWatch}, regWrData & DISCONNECT_MASK);
      if (a == FOLDBACK_LIMIT_SELECT_OFS)
        chk({7'h0, foldbackLevelSel}, regWrData & FOLDBACK_MASK);
    end
    wr(DETECT_CLASSIFY_ENABLE_OFS, 8'h00);
    wr(PORT_POWER_ENABLE_OFS, 8'h1E);
    repeat (3) @(negedge clock);
    chk({4'h0, portOutputPin}, 8'h0E);
    wr(PORT_POWER_ENABLE_OFS, 8'h0F);
    repeat (3) @(negedge clock);
    chk({4'h0, portOutputPin}, 8'h00);
    rd_chk(PORT_POWER_ENABLE_OFS, 8'h0F);
    wr(PORT_POWER_ENABLE_OFS, 8'h1F);
    portOperatingSel = 8'hFC;
    repeat (3) @(negedge clock);
    chk({4'h0, portOutputPin}, 8'h0E);
    portOperatingSel = 8'hFD;
    wr(DETECT_CLASSIFY_ENABLE_OFS, 8'h01);
    repeat (3) @(negedge clock);
    rd_chk(DETECT_CLASSIFY_ENABLE_OFS, 8'h00);
    portOperatingSel = 8'hFE;
    wr(DETECT_CLASSIFY_ENABLE_OFS, 8'h5A);
    repeat (3) @(negedge clock);
    chk({classifyRun, detectRun}, 8'h5A);
    rd_chk(DETECT_CLASSIFY_ENABLE_OFS, 8'h5A);
    portOperatingSel = 8'hFF;
    // one timer per port, random duration code each
    for (int t = 0; t < 4; t++)
    begin
      sel = 2'($urandom);
      lim = (t == 2 ? 128 : 256) << sel;
      wr(FAULT_TIMER_DURATIONS_OFS, 8'(sel) << (6 - 2 * t));
      heavyLoad = 16'h1 << (t * 5);
      wait_lvl(0, t, 1'b0, 5000);
      chk({7'h0, near(n, lim / 16 * TICK)}, 8'h01);
      heavyLoad = 16'h0;
      @(negedge clock);
      chk({6'h0, redetectBlocked[t], portOutputPin[t]}, 8'h02);
      wait_lvl(1, t, 1'b0, 10000);
      chk({7'h0, near(n, lim * TICK)}, 8'h01);
    end
    wait_lvl(0, 1, 1'b1, 50);
    heavyLoad = 16'h0020;
    wait_lvl(0, 1, 1'b0, 5000);
    wr(PORT_POWER_ENABLE_OFS, 8'h1D);
    repeat (2) @(negedge clock);
    chk({7'h0, redetectBlocked[1]}, 8'h00);
    tally_and_finish();
  end
endmodule : pcf_port_config_test
